/* File: verilog/srt_pkg.sv */
`default_nettype none
package srt_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] SRT_ADDR_CONTROL = 8'h91;
  localparam logic [7:0] SRT_ADDR_RELOAD_LOW = 8'h92;
  localparam logic [7:0] SRT_ADDR_RELOAD_HIGH = 8'h93;
  localparam logic [7:0] SRT_ADDR_COUNT_LOW = 8'h94;
  localparam logic [7:0] SRT_ADDR_COUNT_HIGH = 8'h95;
  localparam logic [7:0] SRT_RESET_VALUE = 8'h00;
  // ----------------------------------------
  // control fields
  // ----------------------------------------
  localparam int SRT_BIT_HIGH_FLAG = 7;
  localparam int SRT_BIT_LOW_FLAG = 6;
  localparam int SRT_BIT_LOW_IRQ_EN = 5;
  localparam int SRT_BIT_CAPTURE = 4;
  localparam int SRT_BIT_SPLIT = 3;
  localparam int SRT_BIT_RUN = 2;
  localparam int SRT_BIT_UNUSED = 1;
  localparam int SRT_BIT_EXT_SEL = 0;
  localparam logic [7:0] SRT_CONTROL_WMASK = 8'hFD;
  // ----------------------------------------
  // prescalers
  // ----------------------------------------
  localparam int SRT_SYS_DIV = 12;
  localparam int SRT_EXT_DIV = 8;
  localparam logic [3:0] SRT_SYS_DIV_LAST = 4'(SRT_SYS_DIV - 1);
  localparam logic [2:0] SRT_EXT_DIV_LAST = 3'(SRT_EXT_DIV - 1);
  localparam logic [7:0] SRT_BYTE_ONES = 8'hFF;
endpackage
`default_nettype wire

/* File: verilog/srt_timer.sv */
// Function
// - 16-bit mode counts as one counter; on full wrap reloads and sets high flag.
// - 16-bit mode interrupts on full overflow, plus low wrap when low enable set.
// - split mode runs two 8-bit auto-reload timers, each reloading its own byte.
// - run bit gates whole timer in 16-bit mode, only high byte in split.
// - byte clock select 1 uses system clock, else ext select picks div12 or ext/8.
// - external oscillator is synchronized first, then divided by 8 for use as enable.
// - high flag set on high byte wrap; low flag set on low wrap always.
// - split mode interrupts on high overflow, and low overflow if enabled.
// - hardware never clears the flags; software clears and checks both.
// - setting high flag with interrupt enabled requests the service routine.
// - capture non-split: free 16-bit count, copy to reload on frame start.
// - capture split: two free 8-bit counts, both copied on frame start.
// - reload registers hold reload value, or captured bytes in capture mode.
// - ext select applies to both bytes; byte selects still choose system clock.
// - control bits: flags 7,6, low enable 5, capture 4, split 3, run 2, ext 0.
// - unused control bit 1 reads zero and ignores writes.
`default_nettype none
module srt_timer
  import srt_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  input wire logic ext_osc_clk,
  input wire logic frame_start,
  input wire logic timer_irq_enable,
  input wire logic high_byte_clock_select,
  input wire logic low_byte_clock_select,
  output logic timer_irq
);

  // ----------------------------------------
  // prescaler and external clock sync
  // ----------------------------------------
  logic [3:0] sys_div;
  logic [3:0] next_sys_div;
  logic [2:0] ext_sync;
  logic [2:0] next_ext_sync;
  logic ext_level;
  logic next_ext_level;
  logic [2:0] ext_div;
  logic [2:0] next_ext_div;
  logic sys_tick;
  logic ext_tick;
  logic ext_edge;

  always_comb begin
    sys_tick = (sys_div == SRT_SYS_DIV_LAST);
    next_sys_div = sys_tick ? 4'h0 : sys_div + 4'h1;
    next_ext_sync = {ext_sync[1:0], ext_osc_clk};
    next_ext_level = ext_level;
    ext_edge = 1'b0;
    if (ext_sync[1] == ext_sync[2]) begin
      next_ext_level = ext_sync[2];
      ext_edge = ext_sync[2] & ~ext_level;
    end
    next_ext_div = ext_edge ? ext_div + 3'h1 : ext_div;
    ext_tick = ext_edge && (ext_div == SRT_EXT_DIV_LAST);
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      sys_div <= 4'h0;
      ext_sync <= 3'h0;
      ext_level <= 1'b0;
      ext_div <= 3'h0;
    end else begin
      sys_div <= next_sys_div;
      ext_sync <= next_ext_sync;
      ext_level <= next_ext_level;
      ext_div <= next_ext_div;
    end
  end

  // ----------------------------------------
  // timer core and registers
  // ----------------------------------------
  logic [7:0] control;
  logic [7:0] next_control;
  logic [7:0] reload_low;
  logic [7:0] next_reload_low;
  logic [7:0] reload_high;
  logic [7:0] next_reload_high;
  logic [7:0] count_low;
  logic [7:0] next_count_low;
  logic [7:0] count_high;
  logic [7:0] next_count_high;
  logic [7:0] next_rdata;
  logic next_irq;
  logic split_mode;
  logic capture_mode;
  logic run_control;
  logic ext_sel_tick;
  logic en_low;
  logic en_high;
  logic low_wrap;
  logic high_wrap;
  logic set_high;
  logic set_low;

  always_comb begin
    split_mode = control[SRT_BIT_SPLIT];
    capture_mode = control[SRT_BIT_CAPTURE];
    run_control = control[SRT_BIT_RUN];
    ext_sel_tick = control[SRT_BIT_EXT_SEL] ? ext_tick : sys_tick;
    en_low = low_byte_clock_select ? 1'b1 : ext_sel_tick;
    en_high = high_byte_clock_select ? 1'b1 : ext_sel_tick;
    if (split_mode) begin
      en_high = en_high & run_control;
    end else begin
      en_low = en_low & run_control;
      en_high = en_low;
    end
    low_wrap = en_low && (count_low == SRT_BYTE_ONES);
    if (split_mode) begin
      high_wrap = en_high && (count_high == SRT_BYTE_ONES);
    end else begin
      high_wrap = low_wrap && (count_high == SRT_BYTE_ONES);
    end
    set_high = high_wrap;
    set_low = low_wrap;

    next_count_low = count_low;
    next_count_high = count_high;
    if (split_mode) begin
      if (en_low) begin
        next_count_low = (low_wrap && !capture_mode) ? reload_low : count_low + 8'h01;
      end
      if (en_high) begin
        next_count_high = (high_wrap && !capture_mode) ? reload_high : count_high + 8'h01;
      end
    end else if (en_low) begin
      if (high_wrap && !capture_mode) begin
        next_count_low = reload_low;
        next_count_high = reload_high;
      end else begin
        next_count_low = count_low + 8'h01;
        next_count_high = low_wrap ? count_high + 8'h01 : count_high;
      end
    end

    next_reload_low = reload_low;
    next_reload_high = reload_high;
    if (capture_mode && frame_start) begin
      next_reload_low = count_low;
      next_reload_high = count_high;
    end

    next_control = control;
    if (sfr_wr) begin
      if (sfr_addr == SRT_ADDR_CONTROL) begin
        next_control = sfr_wdata & SRT_CONTROL_WMASK;
      end else if (sfr_addr == SRT_ADDR_RELOAD_LOW) begin
        next_reload_low = sfr_wdata;
      end else if (sfr_addr == SRT_ADDR_RELOAD_HIGH) begin
        next_reload_high = sfr_wdata;
      end else if (sfr_addr == SRT_ADDR_COUNT_LOW) begin
        next_count_low = sfr_wdata;
      end else if (sfr_addr == SRT_ADDR_COUNT_HIGH) begin
        next_count_high = sfr_wdata;
      end
    end
    // set wins over a software clear in the same cycle
    if (set_high) begin
      next_control[SRT_BIT_HIGH_FLAG] = 1'b1;
    end
    if (set_low) begin
      next_control[SRT_BIT_LOW_FLAG] = 1'b1;
    end

    next_rdata = sfr_rdata;
    if (sfr_rd) begin
      if (sfr_addr == SRT_ADDR_CONTROL) begin
        next_rdata = control & SRT_CONTROL_WMASK;
      end else if (sfr_addr == SRT_ADDR_RELOAD_LOW) begin
        next_rdata = reload_low;
      end else if (sfr_addr == SRT_ADDR_RELOAD_HIGH) begin
        next_rdata = reload_high;
      end else if (sfr_addr == SRT_ADDR_COUNT_LOW) begin
        next_rdata = count_low;
      end else if (sfr_addr == SRT_ADDR_COUNT_HIGH) begin
        next_rdata = count_high;
      end else begin
        next_rdata = 8'h00;
      end
    end

    // interrupt follows flags (level) plus a frame capture pulse
    next_irq = timer_irq_enable && (next_control[SRT_BIT_HIGH_FLAG]
      || (next_control[SRT_BIT_LOW_FLAG] && next_control[SRT_BIT_LOW_IRQ_EN])
      || (capture_mode && frame_start));
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      control <= SRT_RESET_VALUE;
      reload_low <= SRT_RESET_VALUE;
      reload_high <= SRT_RESET_VALUE;
      count_low <= SRT_RESET_VALUE;
      count_high <= SRT_RESET_VALUE;
      sfr_rdata <= 8'h00;
      timer_irq <= 1'b0;
    end else begin
      control <= next_control;
      reload_low <= next_reload_low;
      reload_high <= next_reload_high;
      count_low <= next_count_low;
      count_high <= next_count_high;
      sfr_rdata <= next_rdata;
      timer_irq <= next_irq;
    end
  end

endmodule
`default_nettype wire

/* File: bench/srt_monitor.sv */
`default_nettype none
module srt_monitor (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic frame_start,
  input wire logic timer_irq_enable,
  input wire logic timer_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  a_reset_clear: assert property (!$past(rstn) |-> sfr_rdata == 8'h00 && !timer_irq)
    else $error("not clear after reset");
  a_rdata_hold: assert property (!$past(sfr_rd) |-> $stable(sfr_rdata))
    else $error("read data moved");
  a_bit1_zero: assert property ($past(sfr_rd && sfr_addr == 8'h91) |-> !sfr_rdata[1])
    else $error("unused bit set");
  a_unmapped_zero: assert property ($past(sfr_rd && !(sfr_addr inside {[8'h91:8'h95]})) |-> sfr_rdata == 8'h00)
    else $error("unmapped read nonzero");
  a_ctrl_readback: assert property (sfr_wr && sfr_addr == 8'h91 ##1 sfr_rd && sfr_addr == 8'h91
    |=> sfr_rdata[5:2] == $past(sfr_wdata[5:2], 2)) else $error("control readback");
  a_reload_readback: assert property (sfr_wr && sfr_addr inside {8'h92, 8'h93} ##1 sfr_rd && $stable(sfr_addr)
    |=> sfr_rdata == $past(sfr_wdata, 2)) else $error("reload readback");
  a_irq_enable: assert property (!timer_irq_enable && !$past(timer_irq_enable) |-> !timer_irq)
    else $error("irq while disabled");
  a_flag_holds: assert property ((!frame_start && !sfr_wr && timer_irq_enable) [*3] ##0 timer_irq
    |=> timer_irq || !timer_irq_enable) else $error("flag dropped");
endmodule
bind srt_timer srt_monitor u_mon (.ref_clk, .rstn, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata,
  .frame_start, .timer_irq_enable, .timer_irq);
`default_nettype wire

/* File: bench/srt_sof_model.sv */
`default_nettype none
module srt_sof_model (
  input wire logic ref_clk,
  input wire logic [7:0] gap,
  output logic frame_start
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt = 8'h00;
  initial frame_start = 1'b0;
  // one-cycle frame mark every gap+1 cycles, silent while gap is zero
  always @(posedge ref_clk) begin
    cnt <= (gap == 8'h00 || cnt == gap) ? 8'h00 : cnt + 8'h01;
    frame_start <= gap != 8'h00 && cnt == gap;
  end
endmodule
`default_nettype wire

/* File: bench/tb.sv */
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, rstn = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0, ext_osc_clk = 1'b0, timer_irq_enable = 1'b0;
  logic high_byte_clock_select = 1'b1, low_byte_clock_select = 1'b1, frame_start, timer_irq;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, gap = 8'h00, v;
  int fail_count = 0, compares = 0, cyc = 0;
  srt_timer dut (.ref_clk, .rstn, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata, .ext_osc_clk,
    .frame_start, .timer_irq_enable, .high_byte_clock_select, .low_byte_clock_select, .timer_irq);
  srt_sof_model usb (.ref_clk, .gap, .frame_start);
  initial forever #4 ref_clk = ~ref_clk;
  initial forever #21 ext_osc_clk = ~ext_osc_clk;
  task automatic check(input string what, input logic [7:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    sfr_rd <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    sfr_wr <= 1'b0;
    @(posedge ref_clk);
    sfr_rd <= 1'b0;
    @(posedge ref_clk);
    v = sfr_rdata;
  endtask
  task automatic idle(input int n);
    sfr_wr <= 1'b0;
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic results;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      results;
    end
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    for (logic [7:0] a = 8'h91; a <= 8'h96; a++) begin
      rd(a);
      check("reset value", v, 8'h00);
    end
    wr(8'h91, 8'h02);
    rd(8'h91);
    check("unused bit", v, 8'h00);
    $display("register test done");
    timer_irq_enable <= 1'b1;
    wr(8'h92, 8'h00);
    wr(8'h93, 8'hFF);
    rd(8'h93);
    check("reload high", v, 8'hFF);
    wr(8'h94, 8'hFE);
    wr(8'h95, 8'hFF);
    wr(8'h91, 8'h04);
    idle(40);
    check("irq", 8'(timer_irq), 8'h01);
    rd(8'h91);
    check("flags", v, 8'hC4);
    rd(8'h95);
    check("reloaded high", v, 8'hFF);
    wr(8'h91, 8'h00);
    rd(8'h91);
    check("cleared", v, 8'h00);
    $display("16-bit test done");
    wr(8'h92, 8'hFC);
    wr(8'h94, 8'hFE);
    wr(8'h95, 8'h10);
    wr(8'h91, 8'h08);
    idle(20);
    rd(8'h91);
    check("split flags", v, 8'h48);
    rd(8'h95);
    check("high gated", v, 8'h10);
    rd(8'h94);
    check("low reload", 8'(v >= 8'hFC), 8'h01);
    check("no low irq", 8'(timer_irq), 8'h00);
    wr(8'h91, 8'h28);
    idle(10);
    check("low irq", 8'(timer_irq), 8'h01);
    low_byte_clock_select <= 1'b0;
    wr(8'h92, 8'h00);
    wr(8'h94, 8'h00);
    wr(8'h91, 8'h08);
    idle(120);
    rd(8'h94);
    check("div12 count", 8'(v >= 8'h09 && v <= 8'h0B), 8'h01);
    wr(8'h94, 8'h00);
    wr(8'h91, 8'h09);
    idle(400);
    rd(8'h94);
    check("ext count", 8'(v >= 8'h08 && v <= 8'h0B), 8'h01);
    $display("split test done");
    low_byte_clock_select <= 1'b1;
    wr(8'h91, 8'h00);
    wr(8'h95, 8'h12);
    wr(8'h94, 8'h00);
    wr(8'h91, 8'h14);
    gap <= 8'hC8;
    idle(230);
    rd(8'h93);
    check("capture high", v, 8'h12);
    $display("capture test done");
    results;
  end
endmodule
`default_nettype wire
